// *** core/smh_core.v ***
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "smh_defs.vh"
module smh_core #(
   parameter TICK_CYCLES = `SMH_TICK_CYCLES,
   parameter WIN_TICKS = `SMH_WIN_TICKS
) (
   input wire clk,
   input wire rst_n,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire cts_pin,
   output reg rts,
   input wire chr_valid,
   input wire [7:0] chr_data,
   input wire chr_last,
   output wire chr_ready,
   output wire line_valid,
   output reg [7:0] line_data,
   output reg line_last,
   input wire line_ready,
   output reg msg_start,
   input wire ack_seen,
   input wire reply_seen,
   input wire rx_valid,
   input wire [7:0] rx_id,
   output reg rx_pass,
   output reg msg_error,
   output wire irq
);
   // One-hot sequencer states
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RTS_ON = 5'h02;
   localparam [4:0] ST_SEND = 5'h04;
   localparam [4:0] ST_RTS_OFF = 5'h08;
   localparam [4:0] ST_WAIT_ACK = 5'h10;

   // Address match
   function hit;
      input [3:0] addr;
      input [3:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   reg dup_en;
   reg [7:0] send_dly;
   reg [7:0] off_dly;
   reg [15:0] ack_tmo;
   reg [7:0] retry_lim;
   reg [2:0] app_sel;
   reg [`SMH_NEV-1:0] status;
   reg [`SMH_NEV-1:0] mask;
   reg [2:0] ev_seq;
   reg ev_app;
   reg ev_dup;
   wire [`SMH_NEV-1:0] ev;
   reg [4:0] state;
   reg [15:0] dly_cnt;
   reg [7:0] retry_cnt;
   reg line_full;
   reg app_run;
   reg [3:0] app_cnt;
   reg [7:0] last_id;
   reg last_ok;
   wire cts_s;
   wire tick;
   wire win_tick;
   wire start_req;
   wire [`SMH_NEV-1:0] w1c;
   wire line_take;
   wire chr_take;
   wire [3:0] app_lim;

   smh_sync u_cts_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(cts_pin),
      .sync_out(cts_s)
   );

   smh_tick #(
      .TICK_CYCLES(TICK_CYCLES),
      .WIN_TICKS(WIN_TICKS)
   ) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .win_tick(win_tick)
   );

   assign start_req = reg_wr && hit(reg_addr, `SMH_CMD_OFF) &&
                      reg_wdata[`SMH_CMD_START];
   assign w1c = (reg_wr && hit(reg_addr, `SMH_STATUS_OFF)) ?
                reg_wdata[`SMH_NEV-1:0] : {`SMH_NEV{1'b0}};

   // Data leaves only in the send phase with clear-to-send high
   assign line_valid = line_full && cts_s && (state == ST_SEND);
   assign line_take = line_valid && line_ready;
   assign chr_ready = (state == ST_SEND) && cts_s &&
                      !(line_full && line_last) &&
                      (!line_full || line_ready);
   assign chr_take = chr_valid && chr_ready;

   // Configuration registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dup_en <= `SMH_CTRL_RST;
         send_dly <= `SMH_SEND_DLY_RST;
         off_dly <= `SMH_OFF_DLY_RST;
         ack_tmo <= `SMH_ACK_TMO_RST;
         retry_lim <= `SMH_RETRY_RST;
         app_sel <= `SMH_APP_SEL_RST;
         mask <= `SMH_MASK_RST;
      end else if (reg_wr) begin
         if (hit(reg_addr, `SMH_CTRL_OFF)) begin
            dup_en <= reg_wdata[`SMH_CTRL_DUP];
         end
         if (hit(reg_addr, `SMH_SEND_DLY_OFF)) begin
            send_dly <= reg_wdata[7:0];
         end
         if (hit(reg_addr, `SMH_OFF_DLY_OFF)) begin
            off_dly <= reg_wdata[7:0];
         end
         if (hit(reg_addr, `SMH_ACK_TMO_OFF)) begin
            ack_tmo <= reg_wdata;
         end
         if (hit(reg_addr, `SMH_RETRY_OFF)) begin
            retry_lim <= reg_wdata[7:0];
         end
         if (hit(reg_addr, `SMH_APP_SEL_OFF)) begin
            app_sel <= reg_wdata[2:0];
         end
         if (hit(reg_addr, `SMH_MASK_OFF)) begin
            mask <= reg_wdata[`SMH_NEV-1:0];
         end
      end
   end

   // Sticky status, set wins over write-one clear
   genvar gi;
   generate
      for (gi = 0; gi < `SMH_NEV; gi = gi + 1) begin : g_status
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               status[gi] <= 1'b0;
            end else if (ev[gi]) begin
               status[gi] <= 1'b1;
            end else if (w1c[gi]) begin
               status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Event bits, one driver per process
   assign ev = {ev_dup, ev_app, ev_seq};
   assign irq = |(status & mask);

   // Transmit handshake sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         rts <= 1'b0;
         dly_cnt <= 16'h0000;
         retry_cnt <= 8'h00;
         line_full <= 1'b0;
         line_data <= 8'h00;
         line_last <= 1'b0;
         msg_start <= 1'b0;
         ev_seq <= 3'h0;
      end else begin
         msg_start <= 1'b0;
         ev_seq <= 3'h0;
         case (state)
            ST_IDLE: begin
               if (start_req) begin
                  state <= ST_RTS_ON;
                  rts <= 1'b1;
                  dly_cnt <= {8'h00, send_dly};
                  retry_cnt <= 8'h00;
                  msg_start <= 1'b1;
               end
            end
            ST_RTS_ON: begin
               if (dly_cnt == 16'h0000) begin
                  state <= ST_SEND;
               end else if (tick) begin
                  dly_cnt <= dly_cnt - 16'h0001;
               end
            end
            ST_SEND: begin
               if (chr_take) begin
                  line_full <= 1'b1;
                  line_data <= chr_data;
                  line_last <= chr_last;
               end else if (line_take) begin
                  line_full <= 1'b0;
                  line_last <= 1'b0;
                  if (line_last) begin
                     state <= ST_RTS_OFF;
                     dly_cnt <= {8'h00, off_dly};
                  end
               end
            end
            ST_RTS_OFF: begin
               if (dly_cnt == 16'h0000) begin
                  rts <= 1'b0;
                  state <= ST_WAIT_ACK;
                  dly_cnt <= ack_tmo;
               end else if (tick) begin
                  dly_cnt <= dly_cnt - 16'h0001;
               end
            end
            ST_WAIT_ACK: begin
               if (ack_seen) begin
                  state <= ST_IDLE;
                  ev_seq[`SMH_EV_DONE] <= 1'b1;
               end else if (dly_cnt == 16'h0000) begin
                  if (retry_cnt < retry_lim) begin
                     retry_cnt <= retry_cnt + 8'h01;
                     ev_seq[`SMH_EV_ACKTO] <= 1'b1;
                     state <= ST_RTS_ON;
                     rts <= 1'b1;
                     dly_cnt <= {8'h00, send_dly};
                     msg_start <= 1'b1;
                  end else begin
                     ev_seq[`SMH_EV_UNDEL] <= 1'b1;
                     state <= ST_IDLE;
                  end
               end else if (tick) begin
                  dly_cnt <= dly_cnt - 16'h0001;
               end
            end
            default: begin
               state <= ST_IDLE;
               rts <= 1'b0;
               line_full <= 1'b0;
               line_last <= 1'b0;
            end
         endcase
      end
   end

   // Code 0 is treated as code 1; error after n+1 window ticks
   assign app_lim = (app_sel == 3'h0) ? 4'h2 :
                    ({1'b0, app_sel} + 4'h1);

   // Application reply timer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         app_run <= 1'b0;
         app_cnt <= 4'h0;
         msg_error <= 1'b0;
         ev_app <= 1'b0;
      end else begin
         ev_app <= 1'b0;
         if (start_req && (state == ST_IDLE)) begin
            app_run <= 1'b1;
            app_cnt <= 4'h0;
            msg_error <= 1'b0;
         end else if (app_run && reply_seen) begin
            app_run <= 1'b0;
         end else if (app_run && ack_seen) begin
            app_cnt <= 4'h0;
         end else if (app_run && win_tick) begin
            if ((app_cnt + 4'h1) == app_lim) begin
               app_run <= 1'b0;
               msg_error <= 1'b1;
               ev_app <= 1'b1;
            end else begin
               app_cnt <= app_cnt + 4'h1;
            end
         end
      end
   end

   // Duplicate filter on received messages
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_id <= 8'h00;
         last_ok <= 1'b0;
         rx_pass <= 1'b0;
         ev_dup <= 1'b0;
      end else begin
         rx_pass <= 1'b0;
         ev_dup <= 1'b0;
         if (rx_valid) begin
            if (dup_en && last_ok && (rx_id == last_id)) begin
               ev_dup <= 1'b1;
            end else begin
               rx_pass <= 1'b1;
               last_id <= rx_id;
               last_ok <= 1'b1;
            end
         end
      end
   end

   // Register read, data one cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SMH_CTRL_OFF: begin
               reg_rdata <= {15'h0000, dup_en};
            end
            `SMH_SEND_DLY_OFF: begin
               reg_rdata <= {8'h00, send_dly};
            end
            `SMH_OFF_DLY_OFF: begin
               reg_rdata <= {8'h00, off_dly};
            end
            `SMH_ACK_TMO_OFF: begin
               reg_rdata <= ack_tmo;
            end
            `SMH_RETRY_OFF: begin
               reg_rdata <= {8'h00, retry_lim};
            end
            `SMH_APP_SEL_OFF: begin
               reg_rdata <= {13'h0000, app_sel};
            end
            `SMH_STATUS_OFF: begin
               reg_rdata <= {11'h000, status};
            end
            `SMH_MASK_OFF: begin
               reg_rdata <= {11'h000, mask};
            end
            `SMH_STATE_OFF: begin
               reg_rdata <= {retry_cnt, app_run, cts_s, rts, state};
            end
            default: begin
               reg_rdata <= 16'h0000;
            end
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule // smh_core

// *** core/smh_defs.vh ***
// Overview of operation
// - After raising request-to-send, wait the send delay, 0-255 ticks of 20 ms.
// - Message data leaves only while clear-to-send is high; modem raises it.
// - After the last character, hold request-to-send for the off delay, then drop.
// - After sending, wait for acknowledgment at most 0-65535 ticks of 20 ms.
// - With duplicate detection on, a repeated received message is discarded.
// - Reply timeout code n, 1 to 7, gives a 30n to 30n+30 second window.
// - No reply within the selected window sets the message error bit.
// - The reply timer starts when the program first requests the message.
// - Link acknowledgment restarts the reply timer from zero.
// - Retry an unacknowledged message up to 0-255 times, then declare undeliverable.
`ifndef SMH_DEFS_VH
`define SMH_DEFS_VH

// Timing
`define SMH_CLK_HZ 100000000
`define SMH_TICK_MS 20
`define SMH_TICK_CYCLES ((`SMH_CLK_HZ / 1000) * `SMH_TICK_MS)
`define SMH_WIN_S 30
`define SMH_WIN_TICKS ((`SMH_WIN_S * 1000) / `SMH_TICK_MS)

// Register offsets
`define SMH_CTRL_OFF 4'h0
`define SMH_SEND_DLY_OFF 4'h1
`define SMH_OFF_DLY_OFF 4'h2
`define SMH_ACK_TMO_OFF 4'h3
`define SMH_RETRY_OFF 4'h4
`define SMH_APP_SEL_OFF 4'h5
`define SMH_STATUS_OFF 4'h6
`define SMH_MASK_OFF 4'h7
`define SMH_STATE_OFF 4'h8
`define SMH_CMD_OFF 4'h9

// Fields
`define SMH_CTRL_DUP 0
`define SMH_CMD_START 0
`define SMH_NEV 5
`define SMH_EV_DONE 0
`define SMH_EV_ACKTO 1
`define SMH_EV_UNDEL 2
`define SMH_EV_APPERR 3
`define SMH_EV_DUP 4

// Reset values
`define SMH_CTRL_RST 1'b0
`define SMH_SEND_DLY_RST 8'h00
`define SMH_OFF_DLY_RST 8'h00
`define SMH_ACK_TMO_RST 16'h0032
`define SMH_RETRY_RST 8'h03
`define SMH_APP_SEL_RST 3'h1
`define SMH_MASK_RST 5'h00

`endif

// *** core/smh_sync.v ***
`timescale 1ns/100ps
module smh_sync (
   input wire clk,
   input wire rst_n,
   input wire async_in,
   output reg sync_out
);
   reg stage1;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // smh_sync

// *** core/smh_tick.v ***
`timescale 1ns/100ps
module smh_tick #(
   parameter TICK_CYCLES = 2000000,
   parameter WIN_TICKS = 1500
) (
   input wire clk,
   input wire rst_n,
   output reg tick,
   output reg win_tick
);
   localparam integer TICK_L = TICK_CYCLES - 1;
   localparam integer WIN_L = WIN_TICKS - 1;
   localparam [23:0] TICK_LAST = TICK_L[23:0];
   localparam [15:0] WIN_LAST = WIN_L[15:0];
   reg [23:0] pre_cnt;
   reg [15:0] win_cnt;

   // Prescaler for the 20 ms tick and the 30 s window
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 24'h000000;
         win_cnt <= 16'h0000;
         tick <= 1'b0;
         win_tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         win_tick <= 1'b0;
         if (pre_cnt == TICK_LAST) begin
            pre_cnt <= 24'h000000;
            tick <= 1'b1;
            if (win_cnt == WIN_LAST) begin
               win_cnt <= 16'h0000;
               win_tick <= 1'b1;
            end else begin
               win_cnt <= win_cnt + 16'h0001;
            end
         end else begin
            pre_cnt <= pre_cnt + 24'h000001;
         end
      end
   end
endmodule // smh_tick

// *** testbench/serial_modem_handshake_timing_tb.sv ***
`timescale 1ns/100ps
module serial_modem_handshake_timing_tb;
   reg clk, rst_n, reg_wr, reg_rd, chr_valid, chr_last, ack_en;
   reg reply_seen, rx_valid;
   reg [3:0] reg_addr;
   reg [15:0] reg_wdata, got;
   reg [7:0] chr_data, rx_id;
   reg [7:0] message_instruction [0:1];
   reg [31:0] s;
   wire [15:0] reg_rdata;
   wire cts_pin, rts, chr_ready, line_valid, line_last, line_ready;
   wire msg_start, ack_seen, rx_pass, msg_error, irq;
   wire [7:0] line_data;
   integer errors, tests_run, n, k, nstart, c, i, last;
   smh_core #(.TICK_CYCLES(10), .WIN_TICKS(4)) i_smh_core (.clk(clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cts_pin(cts_pin), .rts(rts), .chr_valid(chr_valid),
      .chr_data(chr_data), .chr_last(chr_last), .chr_ready(chr_ready),
      .line_valid(line_valid), .line_data(line_data),
      .line_last(line_last), .line_ready(line_ready),
      .msg_start(msg_start), .ack_seen(ack_seen),
      .reply_seen(reply_seen), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_pass(rx_pass), .msg_error(msg_error), .irq(irq));
   smh_modem i_smh_modem (.clk(clk), .rst_n(rst_n), .rts(rts),
      .ack_en(ack_en), .cts_pin(cts_pin), .line_ready(line_ready),
      .ack_seen(ack_seen));
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task test_done;
      $display("tests %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      tests_run = tests_run + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) got = reg_rdata;
      @(posedge clk);
   endtask
   task wfor(input integer sel);
      c = 0;
      while (!(sel == 0 ? rts === 1'b1 : sel == 1 ? chr_ready === 1'b1 :
         sel == 2 ? ack_seen === 1'b1 : sel == 3 ? msg_error === 1'b1 :
         irq === 1'b1)) begin
         @(posedge clk);
         c = c + 1;
         if (c > 3000) begin
            errors = errors + 1;
            test_done;
         end
      end
   endtask
   task rx(input [7:0] id, input dup);
      rx_valid <= 1'b1;
      rx_id <= id;
      @(posedge clk) rx_valid <= 1'b0;
      @(negedge clk) chk(rx_pass, !(dup && id == last));
      if (!(dup && id == last)) last = id;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (msg_start) begin
         n = 0;
         k = 0;
         nstart = nstart + 1;
      end else if (chr_valid && chr_ready) n = n + 1;
      if (line_valid && line_ready) begin
         chk(line_data, message_instruction[k]);
         chk(line_last, k == 1);
         k = k + 1;
      end
      chr_valid <= n < 2;
      chr_data <= message_instruction[n % 2];
      chr_last <= n == 1;
   end
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, reg_wr, reg_rd, chr_valid, chr_last, ack_en} = 6'h00;
      {reply_seen, rx_valid, reg_addr, reg_wdata, chr_data, rx_id} = 0;
      errors = 0;
      tests_run = 0;
      n = 2;
      k = 0;
      nstart = 0;
      last = -1;
      s = 32'hD0D26C51;
      message_instruction[0] = 8'h00;
      message_instruction[1] = 8'h00;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 16; i = i + 1) begin
         rd(i);
         chk(got, i == 3 ? 16'h0032 : i == 4 ? 16'h0003 :
            (i == 5 || i == 8) ? 16'h0001 : 16'h0000);
      end
      $display("test reset done");
      s = lfsr(s);
      message_instruction[0] = s[7:0];
      message_instruction[1] = s[15:8];
      ack_en <= 1'b1;
      wr(1, 16'h0002);
      wr(2, 16'h0001);
      wr(9, 16'h0001);
      wfor(0);
      wfor(1);
      chk(c >= 8 && c <= 24, 1);
      wfor(2);
      @(posedge clk);
      rd(6);
      chk(got & 16'h0001, 16'h0001);
      wr(6, 16'h001F);
      $display("test transmit done");
      ack_en <= 1'b0;
      wr(3, 16'h0002);
      wr(4, 16'h0001);
      wr(1, 16'h0000);
      wr(7, 16'h0004);
      nstart = 0;
      wr(9, 16'h0001);
      wfor(4);
      chk(nstart, 2);
      rd(6);
      chk(got & 16'h0007, 16'h0006);
      wr(7, 16'h0000);
      chk(irq, 0);
      wr(6, 16'h001F);
      $display("test retry done");
      ack_en <= 1'b1;
      wr(9, 16'h0001);
      wfor(2);
      wfor(3);
      chk(c >= 38 && c <= 82, 1);
      rd(6);
      chk(got & 16'h0008, 16'h0008);
      wr(6, 16'h001F);
      wr(9, 16'h0001);
      wfor(2);
      reply_seen <= 1'b1;
      @(posedge clk) reply_seen <= 1'b0;
      repeat (120) @(posedge clk);
      chk(msg_error, 0);
      $display("test reply timer done");
      wr(0, 16'h0001);
      s = lfsr(s);
      rx(s[7:0], 1);
      rx(s[7:0], 1);
      rx(s[15:8], 1);
      rd(6);
      chk(got & 16'h0010, 16'h0010);
      wr(0, 16'h0000);
      rx(s[15:8], 0);
      $display("test duplicate done");
      test_done;
   end
endmodule // serial_modem_handshake_timing_tb

// *** testbench/smh_core_asserts.sv ***
`timescale 1ns/100ps
module smh_core_asserts (
   input wire clk,
   input wire rst_n,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire cts_pin,
   input wire rts,
   input wire chr_ready,
   input wire line_valid,
   input wire [7:0] line_data,
   input wire line_ready,
   input wire msg_start,
   input wire rx_valid,
   input wire rx_pass,
   input wire msg_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_cts; line_valid |-> $past(cts_pin, 2); endproperty
   a_cts: assert property (p_cts)
      else $error("line data without clear-to-send");
   property p_lv_rts; line_valid |-> rts; endproperty
   a_lv_rts: assert property (p_lv_rts)
      else $error("line data without request-to-send");
   property p_rdy_rts; chr_ready |-> rts; endproperty
   a_rdy_rts: assert property (p_rdy_rts)
      else $error("character taken without request-to-send");
   property p_rose_rts; $rose(rts) |-> msg_start; endproperty
   a_rose_rts: assert property (p_rose_rts)
      else $error("request-to-send rose without start");
   property p_fell_rts; $fell(rts) |-> !line_valid && !chr_ready;
   endproperty
   a_fell_rts: assert property (p_fell_rts)
      else $error("request-to-send dropped during send");
   property p_pulse; msg_start |=> !msg_start; endproperty
   a_pulse: assert property (p_pulse)
      else $error("start pulse longer than one cycle");
   property p_rx; rx_pass |-> $past(rx_valid); endproperty
   a_rx: assert property (p_rx)
      else $error("receive pass without message");
   property p_rd; reg_rdata != 16'h0000 |-> $past(reg_rd); endproperty
   a_rd: assert property (p_rd)
      else $error("read data outside read cycle");
   property p_hold; line_valid && !line_ready |=> $stable(line_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("line data changed while stalled");
   c_start: cover property (msg_start);
   c_rx: cover property (rx_pass);
   c_err: cover property ($rose(msg_error));
endmodule // smh_core_asserts
bind smh_core smh_core_asserts i_smh_core_asserts (.clk(clk),
   .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .cts_pin(cts_pin), .rts(rts), .chr_ready(chr_ready),
   .line_valid(line_valid), .line_data(line_data),
   .line_ready(line_ready), .msg_start(msg_start),
   .rx_valid(rx_valid), .rx_pass(rx_pass), .msg_error(msg_error));

// *** testbench/smh_modem.sv ***
`timescale 1ns/100ps
module smh_modem (
   input wire clk,
   input wire rst_n,
   input wire rts,
   input wire ack_en,
   output reg cts_pin,
   output reg line_ready,
   output reg ack_seen
);
   reg rts_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cts_pin <= 1'b0;
         line_ready <= 1'b0;
         ack_seen <= 1'b0;
         rts_q <= 1'b0;
      end else begin
         cts_pin <= rts;
         line_ready <= ~line_ready;
         rts_q <= rts;
         ack_seen <= ack_en && rts_q && !rts;
      end
   end
endmodule // smh_modem
